// ### pkg/dcd_pkg.sv
package dcd_pkg;
  // Bus widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_DIV0_CNT = 10'h190;
  localparam logic [ADDR_W-1:0] OFF_DIV0_CTL = 10'h191;
  localparam logic [ADDR_W-1:0] OFF_DIV0_RTE = 10'h192;
  localparam logic [ADDR_W-1:0] OFF_DIV1_CNT = 10'h196;
  localparam logic [ADDR_W-1:0] OFF_DIV1_CTL = 10'h197;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 10'h19f;

  // Count register fields
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 4;
  localparam int HIGH_MSB = 3;
  localparam int HIGH_LSB = 0;

  // Control register fields
  localparam int CTL_BYPASS = 7;
  localparam int CTL_NOSYNC = 6;
  localparam int CTL_FORCE = 5;
  localparam int CTL_START = 4;
  localparam int PHASE_MSB = 3;
  localparam int PHASE_LSB = 0;

  // Routing register fields and writable mask
  localparam int RTE_DIRECT = 1;
  localparam int RTE_DUTY_CORRECTION_DISABLE = 0;
  localparam logic [DATA_W-1:0] RTE_MASK = 8'h03;

  // Status register fields
  localparam int ST_DIFF_PAIR0_FIRST = 0;
  localparam int ST_DIFF_PAIR0_SECOND = 1;
  localparam int ST_RUN0 = 2;
  localparam int ST_RUN1 = 3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CNT = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIV0_CTL = 8'h80;
  localparam logic [DATA_W-1:0] RST_DIV1_CTL = 8'h00;
  localparam logic [DATA_W-1:0] RST_RTE = 8'h00;

  // Clock-source selector codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_DIVONLY = 2'h1;
  localparam logic [1:0] SRC_OSC = 2'h2;

  // Divider sequencing
  typedef enum logic [1:0] {ST_DELAY, ST_LOW, ST_HIGH} dcd_state_t;
endpackage : dcd_pkg

// ### pkg/dcd_div_if.sv
`timescale 1ns/1ps
interface dcd_div_if;
  logic [dcd_pkg::CNT_W-1:0] lowCnt;
  logic [dcd_pkg::CNT_W-1:0] highCnt;
  logic [dcd_pkg::CNT_W-1:0] phase;
  logic bypass;
  logic noSync;
  logic forceHigh;
  logic startHigh;
  logic divOut;
  logic running;

  // Register side drives settings, reads the divider state
  modport cfg (output lowCnt, highCnt, phase, bypass, noSync, forceHigh, startHigh,
               input divOut, running);
  // Divider side
  modport div (input lowCnt, highCnt, phase, bypass, noSync, forceHigh, startHigh,
               output divOut, running);
endinterface : dcd_div_if

// ### core/dcd_divider.sv
`timescale 1ns/1ps
module dcd_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Divider input clock, as level and rising-edge tick
  input wire logic inLevel,
  input wire logic inTick,
  // Chip-level synchronisation
  input wire logic syncReq,
  // Settings and result
  dcd_div_if.div d
);
  dcd_pkg::dcd_state_t state_r;
  logic [dcd_pkg::CNT_W-1:0] cnt_r;
  logic runLevel;

  ////////////////////////////////////////////////////////////////////////
  // Low/high sequencing on input ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= dcd_pkg::ST_DELAY;
      cnt_r <= '0;
    end else if (d.bypass || (syncReq && !d.noSync)) begin
      state_r <= dcd_pkg::ST_DELAY;
      cnt_r <= d.phase;
    end else if (inTick) begin
      if (cnt_r != '0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (state_r == dcd_pkg::ST_LOW) begin
        state_r <= dcd_pkg::ST_HIGH;
        cnt_r <= d.highCnt;
      end else if (state_r == dcd_pkg::ST_HIGH) begin
        state_r <= dcd_pkg::ST_LOW;
        cnt_r <= d.lowCnt;
      end else begin
        state_r <= d.startHigh ? dcd_pkg::ST_HIGH : dcd_pkg::ST_LOW;
        cnt_r <= d.startHigh ? d.highCnt : d.lowCnt;
      end
    end
  end

  // Level implied by the sequencer
  assign runLevel = (state_r == dcd_pkg::ST_HIGH) ||
                    (state_r == dcd_pkg::ST_DELAY && d.startHigh);

  ////////////////////////////////////////////////////////////////////////
  // Output level: bypass, forced, or divided
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      d.divOut <= 1'b0;
    end else if (d.bypass) begin
      d.divOut <= inLevel;
    end else if (syncReq && d.noSync) begin
      d.divOut <= d.forceHigh;
    end else begin
      d.divOut <= runLevel;
    end
  end

  assign d.running = !d.bypass && (state_r != dcd_pkg::ST_DELAY);
endmodule : dcd_divider

// ### core/dcd_route.sv
`timescale 1ns/1ps
module dcd_route (
  // Routing controls
  input wire logic directRoute,
  input wire logic [1:0] clkSrcSel,
  // Candidate levels
  input wire logic oscLevel,
  input wire logic extLevel,
  input wire logic divLevel,
  // Selected level for the pair
  output logic pairLevel
);
  // Direct path only for oscillator or external input sources
  always_comb begin
    pairLevel = divLevel;
    if (directRoute) begin
      case (clkSrcSel)
        dcd_pkg::SRC_OSC: pairLevel = oscLevel;
        dcd_pkg::SRC_EXT: pairLevel = extLevel;
        default: pairLevel = divLevel;
      endcase
    end
  end
endmodule : dcd_route

// ### core/dcd_top.sv
`timescale 1ns/1ps
module dcd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [dcd_pkg::ADDR_W-1:0] regAddr,
  input wire logic [dcd_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [dcd_pkg::DATA_W-1:0] regRdata,
  // Clock sources and selector
  input wire logic oscClk,
  input wire logic extClk,
  input wire logic [1:0] clkSrcSel,
  // Chip-level synchronisation
  input wire logic syncReq,
  // Outputs
  output logic diffPair0First,
  output logic diffPair0Second,
  output logic div1Out,
  output logic dutyCorrectionDisable
);
  logic [dcd_pkg::DATA_W-1:0] div0Cnt_r;
  logic [dcd_pkg::DATA_W-1:0] div0Ctl_r;
  logic [dcd_pkg::DATA_W-1:0] div0Rte_r;
  logic [dcd_pkg::DATA_W-1:0] div1Cnt_r;
  logic [dcd_pkg::DATA_W-1:0] div1Ctl_r;
  logic [dcd_pkg::DATA_W-1:0] rdNxt;
  logic [dcd_pkg::DATA_W-1:0] status;
  logic divInLevel;
  logic divInPrev_r;
  logic divInTick;
  logic pairLevel;

  dcd_div_if d0 ();
  dcd_div_if d1 ();

  // Address match for a given offset
  function automatic logic hit(input logic [dcd_pkg::ADDR_W-1:0] addr,
                               input logic [dcd_pkg::ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div0Cnt_r <= dcd_pkg::RST_CNT;
      div0Ctl_r <= dcd_pkg::RST_DIV0_CTL;
      div0Rte_r <= dcd_pkg::RST_RTE;
      div1Cnt_r <= dcd_pkg::RST_CNT;
      div1Ctl_r <= dcd_pkg::RST_DIV1_CTL;
    end else if (regWr) begin
      if (hit(regAddr, dcd_pkg::OFF_DIV0_CNT)) begin
        div0Cnt_r <= regWdata;
      end
      if (hit(regAddr, dcd_pkg::OFF_DIV0_CTL)) begin
        div0Ctl_r <= regWdata;
      end
      if (hit(regAddr, dcd_pkg::OFF_DIV0_RTE)) begin
        div0Rte_r <= regWdata & dcd_pkg::RTE_MASK;
      end
      if (hit(regAddr, dcd_pkg::OFF_DIV1_CNT)) begin
        div1Cnt_r <= regWdata;
      end
      if (hit(regAddr, dcd_pkg::OFF_DIV1_CTL)) begin
        div1Ctl_r <= regWdata;
      end
    end
  end

  // Live divider state for software
  always_comb begin
    status = '0;
    status[dcd_pkg::ST_DIFF_PAIR0_FIRST] = d0.divOut;
    status[dcd_pkg::ST_DIFF_PAIR0_SECOND] = d1.divOut;
    status[dcd_pkg::ST_RUN0] = d0.running;
    status[dcd_pkg::ST_RUN1] = d1.running;
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    rdNxt = '0;
    if (hit(regAddr, dcd_pkg::OFF_DIV0_CNT)) rdNxt = div0Cnt_r;
    if (hit(regAddr, dcd_pkg::OFF_DIV0_CTL)) rdNxt = div0Ctl_r;
    if (hit(regAddr, dcd_pkg::OFF_DIV0_RTE)) rdNxt = div0Rte_r;
    if (hit(regAddr, dcd_pkg::OFF_DIV1_CNT)) rdNxt = div1Cnt_r;
    if (hit(regAddr, dcd_pkg::OFF_DIV1_CTL)) rdNxt = div1Ctl_r;
    if (hit(regAddr, dcd_pkg::OFF_STATUS)) rdNxt = status;
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? rdNxt : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings to the dividers
  assign d0.lowCnt = div0Cnt_r[dcd_pkg::LOW_MSB:dcd_pkg::LOW_LSB];
  assign d0.highCnt = div0Cnt_r[dcd_pkg::HIGH_MSB:dcd_pkg::HIGH_LSB];
  assign d0.phase = div0Ctl_r[dcd_pkg::PHASE_MSB:dcd_pkg::PHASE_LSB];
  assign d0.bypass = div0Ctl_r[dcd_pkg::CTL_BYPASS];
  assign d0.noSync = div0Ctl_r[dcd_pkg::CTL_NOSYNC];
  assign d0.forceHigh = div0Ctl_r[dcd_pkg::CTL_FORCE];
  assign d0.startHigh = div0Ctl_r[dcd_pkg::CTL_START];
  assign d1.lowCnt = div1Cnt_r[dcd_pkg::LOW_MSB:dcd_pkg::LOW_LSB];
  assign d1.highCnt = div1Cnt_r[dcd_pkg::HIGH_MSB:dcd_pkg::HIGH_LSB];
  assign d1.phase = div1Ctl_r[dcd_pkg::PHASE_MSB:dcd_pkg::PHASE_LSB];
  assign d1.bypass = div1Ctl_r[dcd_pkg::CTL_BYPASS];
  assign d1.noSync = div1Ctl_r[dcd_pkg::CTL_NOSYNC];
  assign d1.forceHigh = div1Ctl_r[dcd_pkg::CTL_FORCE];
  assign d1.startHigh = div1Ctl_r[dcd_pkg::CTL_START];

  // Divider input: external input for source 00b, else oscillator
  assign divInLevel = (clkSrcSel == dcd_pkg::SRC_EXT) ? extClk : oscClk;

  // Rising edges of the divider input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divInPrev_r <= 1'b0;
    end else begin
      divInPrev_r <= divInLevel;
    end
  end
  assign divInTick = divInLevel && !divInPrev_r;

  ////////////////////////////////////////////////////////////////////////
  // The two channel dividers
  dcd_divider u_div0 (
    .clk(clk),
    .resetn(resetn),
    .inLevel(divInLevel),
    .inTick(divInTick),
    .syncReq(syncReq),
    .d(d0)
  );

  dcd_divider u_div1 (
    .clk(clk),
    .resetn(resetn),
    .inLevel(divInLevel),
    .inTick(divInTick),
    .syncReq(syncReq),
    .d(d1)
  );

  // Source for the first differential pair
  dcd_route u_route (
    .directRoute(div0Rte_r[dcd_pkg::RTE_DIRECT]),
    .clkSrcSel(clkSrcSel),
    .oscLevel(oscClk),
    .extLevel(extClk),
    .divLevel(d0.divOut),
    .pairLevel(pairLevel)
  );

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      diffPair0First <= 1'b0;
      diffPair0Second <= 1'b0;
      div1Out <= 1'b0;
      dutyCorrectionDisable <= 1'b0;
    end else begin
      diffPair0First <= pairLevel;
      diffPair0Second <= pairLevel;
      div1Out <= d1.divOut;
      dutyCorrectionDisable <= div0Rte_r[dcd_pkg::RTE_DUTY_CORRECTION_DISABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checking helpers: tick counts per phase of divider zero
  logic [5:0] lowTicks_r;
  logic [5:0] highTicks_r;
  logic [5:0] lastLow_r;
  logic lowValid_r;
  logic highValid_r;
  logic periodValid_r;
  logic ctl0Written_r;
  logic upset;
  logic outPrev_r;

  assign upset = regWr || d0.bypass || (syncReq && !d0.noSync) || (syncReq && d0.noSync);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outPrev_r <= 1'b0;
      lowTicks_r <= '0;
      highTicks_r <= '0;
      lastLow_r <= '0;
      lowValid_r <= 1'b0;
      highValid_r <= 1'b0;
      periodValid_r <= 1'b0;
    end else begin
      outPrev_r <= d0.divOut;
      if (d0.divOut != outPrev_r) begin
        // A tick landing on the change cycle already belongs to the new phase
        lowTicks_r <= {5'h00, divInTick && !d0.divOut};
        highTicks_r <= {5'h00, divInTick && d0.divOut};
        lowValid_r <= !upset && !d0.divOut && d0.running;
        highValid_r <= !upset && d0.divOut && d0.running;
        if (d0.divOut) begin
          lastLow_r <= lowTicks_r;
          periodValid_r <= lowValid_r && !upset;
        end
      end else begin
        if (divInTick && !d0.divOut) lowTicks_r <= lowTicks_r + 6'h1;
        if (divInTick && d0.divOut) highTicks_r <= highTicks_r + 6'h1;
        if (upset) begin
          lowValid_r <= 1'b0;
          highValid_r <= 1'b0;
          periodValid_r <= 1'b0;
        end
      end
    end
  end

  // Remembers whether control zero was ever written
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl0Written_r <= 1'b0;
    end else if (regWr && hit(regAddr, dcd_pkg::OFF_DIV0_CTL)) begin
      ctl0Written_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_sync_held;
    syncReq && !d0.noSync && !d0.bypass && !regWr;
  endsequence

  sequence s_force_held;
    syncReq && d0.noSync && !d0.bypass && !regWr;
  endsequence

  a_low_width: assert property (
    $rose(d0.divOut) && lowValid_r && !upset |-> lowTicks_r == {2'h0, d0.lowCnt} + 6'h1)
    else $error("low phase length wrong");

  a_high_width: assert property (
    $fell(d0.divOut) && highValid_r && !upset |-> highTicks_r == {2'h0, d0.highCnt} + 6'h1)
    else $error("high phase length wrong");

  a_period_sum: assert property (
    $fell(d0.divOut) && highValid_r && periodValid_r && !upset |->
      lastLow_r + highTicks_r == {2'h0, d0.lowCnt} + {2'h0, d0.highCnt} + 6'h2)
    else $error("divider period wrong");

  a_bypass_pass: assert property (
    d0.bypass && !regWr |=> d0.divOut == $past(divInLevel))
    else $error("bypass does not pass input");

  a_reset_bypass: assert property (
    !ctl0Written_r |-> d0.bypass)
    else $error("divider zero not bypassed after reset");

  a_sync_start: assert property (
    s_sync_held ##1 s_sync_held |=> d0.divOut == d0.startHigh)
    else $error("sync does not hold start level");

  a_force_level: assert property (
    s_force_held |=> d0.divOut == $past(d0.forceHigh))
    else $error("forced level not shown");

  a_route_div: assert property (
    !div0Rte_r[dcd_pkg::RTE_DIRECT] |=> diffPair0First == $past(d0.divOut) &&
      diffPair0Second == diffPair0First)
    else $error("pair not driven by divider");

  a_route_direct: assert property (
    div0Rte_r[dcd_pkg::RTE_DIRECT] && clkSrcSel == dcd_pkg::SRC_OSC |=>
      diffPair0First == $past(oscClk))
    else $error("oscillator not routed to pair");

  a_route_none: assert property (
    div0Rte_r[dcd_pkg::RTE_DIRECT] && clkSrcSel == dcd_pkg::SRC_DIVONLY |=>
      diffPair0First == $past(d0.divOut))
    else $error("direct route acted for source 01b");

  a_dcc_bit: assert property (
    regWr && hit(regAddr, dcd_pkg::OFF_DIV0_RTE) |=> ##1
      dutyCorrectionDisable == $past(regWdata[dcd_pkg::RTE_DUTY_CORRECTION_DISABLE], 2))
    else $error("duty correction disable not applied");

  a_div1_bypass: assert property (
    d1.bypass && !regWr |=> ##1 div1Out == $past(divInLevel, 2))
    else $error("second divider bypass wrong");
endmodule : dcd_top

// ### sim/dcd_top_test.sv
`timescale 1ns/1ps
module dcd_top_test;
  ////////////////////////////////////////////////////////////////
  // Stimulus, observation and bookkeeping
  logic clk;
  logic resetn;
  logic [dcd_pkg::ADDR_W-1:0] regAddr;
  logic [dcd_pkg::DATA_W-1:0] regWdata;
  logic regWr;
  logic regRd;
  logic [dcd_pkg::DATA_W-1:0] regRdata;
  logic oscClk = 1'b0;
  logic extClk = 1'b0;
  logic [1:0] clkSrcSel;
  logic syncReq;
  logic diffPair0First;
  logic diffPair0Second;
  logic div1Out;
  logic dutyCorrectionDisable;
  logic oscD = 1'b0;
  logic extD = 1'b0;
  logic [1:0] extDiv = 2'h0;
  int errCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  int hi;
  int lo;

  dcd_top dut_u (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .oscClk(oscClk),
    .extClk(extClk), .clkSrcSel(clkSrcSel), .syncReq(syncReq),
    .diffPair0First(diffPair0First), .diffPair0Second(diffPair0Second),
    .div1Out(div1Out), .dutyCorrectionDisable(dutyCorrectionDisable)
  );

  // Clock source
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Oscillator toggles each cycle, external input every two; delayed copies; hang guard
  always @(posedge clk) begin
    oscClk <= ~oscClk;
    extDiv <= extDiv + 2'h1;
    extClk <= extDiv[1];
    oscD <= oscClk;
    extD <= extClk;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errCount++;
      $display("[ERR] %0t: run did not finish in time", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task results();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task chkn(input int got, input int exp);
    cmpCount++;
    if (got != exp) begin
      errCount++;
      $display("[ERR] %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : chkn

  task step();
    @(posedge clk);
    #1;
  endtask : step

  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task rdChk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk8(regRdata, exp);
  endtask : rdChk

  function automatic logic pick(input int s);
    return (s == 0) ? div1Out : diffPair0First;
  endfunction : pick

  // Lengths of one high run and the following low run, in clk cycles
  task runLen(input int s, output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (pick(s) !== 1'b0 && n < 200) begin step(); n++; end
    while (pick(s) !== 1'b1 && n < 400) begin step(); n++; end
    while (pick(s) === 1'b1 && n < 600) begin step(); h++; n++; end
    while (pick(s) === 1'b0 && n < 800) begin step(); l++; n++; end
  endtask : runLen

  task checkStatic(input int s, input logic exp, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      step();
      if (pick(s) !== exp) bad++;
    end
    chkn(bad, 0);
  endtask : checkStatic

  task checkFollow(input logic useOsc, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      step();
      if (diffPair0First !== (useOsc ? oscD : extD)) bad++;
      if (diffPair0Second !== diffPair0First) bad++;
    end
    chkn(bad, 0);
  endtask : checkFollow

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task tResetValues();
    runLen(1, hi, lo);
    chkn(hi + lo, 2);
    rdChk(dcd_pkg::OFF_DIV0_CNT, 8'h00);
    rdChk(dcd_pkg::OFF_DIV0_CTL, 8'h80);
    rdChk(dcd_pkg::OFF_DIV0_RTE, 8'h00);
    rdChk(dcd_pkg::OFF_DIV1_CNT, 8'h00);
    rdChk(dcd_pkg::OFF_DIV1_CTL, 8'h00);
    rdChk(10'h1a0, 8'h00);
  endtask : tResetValues

  task tRegisters();
    wr(dcd_pkg::OFF_DIV0_RTE, 8'hfd);
    rdChk(dcd_pkg::OFF_DIV0_RTE, 8'h01);
    step();
    chk8({7'h00, dutyCorrectionDisable}, 8'h01);
    wr(dcd_pkg::OFF_DIV1_CTL, 8'h0f);
    rdChk(dcd_pkg::OFF_DIV1_CTL, 8'h0f);
    wr(10'h1a0, 8'h55);
    rdChk(10'h1a0, 8'h00);
    wr(dcd_pkg::OFF_DIV0_RTE, 8'h00);
    step();
    step();
    chk8({7'h00, dutyCorrectionDisable}, 8'h00);
  endtask : tRegisters

  // Division ratio from the count fields, one input tick per two clk cycles
  task tDivide();
    logic [7:0] tbl [4] = '{8'h00, 8'hf0, 8'h0f, 8'h3a};
    foreach (tbl[i]) begin
      wr(dcd_pkg::OFF_DIV1_CNT, tbl[i]);
      wr(dcd_pkg::OFF_DIV1_CTL, 8'h00);
      repeat (80) step();
      runLen(0, hi, lo);
      chkn(hi, 2 * (int'(tbl[i][3:0]) + 1));
      chkn(lo, 2 * (int'(tbl[i][7:4]) + 1));
      chkn(hi + lo, 2 * (int'(tbl[i][3:0]) + int'(tbl[i][7:4]) + 2));
    end
    wr(dcd_pkg::OFF_DIV1_CTL, 8'h80);
    repeat (4) step();
    runLen(0, hi, lo);
    chkn(hi + lo, 2);
  endtask : tDivide

  // Sync, start level and forced level on divider one
  task tSyncForce();
    logic [7:0] ctl [4] = '{8'h10, 8'h00, 8'h60, 8'h40};
    logic lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(dcd_pkg::OFF_DIV1_CNT, 8'h33);
    @(posedge clk);
    syncReq <= 1'b1;
    foreach (ctl[i]) begin
      wr(dcd_pkg::OFF_DIV1_CTL, ctl[i]);
      repeat (6) step();
      checkStatic(0, lvl[i], 12);
    end
    @(posedge clk);
    syncReq <= 1'b0;
    wr(dcd_pkg::OFF_DIV1_CTL, 8'h00);
    repeat (80) step();
    runLen(0, hi, lo);
    chkn(hi, 8);
  endtask : tSyncForce

  // Pair routing against selector and direct bit
  task tRoute();
    wr(dcd_pkg::OFF_DIV0_CNT, 8'h31);
    wr(dcd_pkg::OFF_DIV0_CTL, 8'h00);
    repeat (40) step();
    runLen(1, hi, lo);
    chkn(hi, 4);
    chkn(lo, 8);
    wr(dcd_pkg::OFF_DIV0_RTE, 8'h02);
    repeat (4) step();
    checkFollow(1'b1, 16);
    @(posedge clk);
    clkSrcSel <= dcd_pkg::SRC_EXT;
    repeat (4) step();
    checkFollow(1'b0, 16);
    @(posedge clk);
    clkSrcSel <= dcd_pkg::SRC_DIVONLY;
    repeat (40) step();
    runLen(1, hi, lo);
    chkn(hi, 4);
    chkn(lo, 8);
  endtask : tRoute

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    resetn = 1'b0;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    clkSrcSel = dcd_pkg::SRC_OSC;
    syncReq = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    tResetValues();
    tRegisters();
    tDivide();
    tSyncForce();
    tRoute();
    results();
  end
endmodule : dcd_top_test
